// [verilog/ass_pkg.sv]
// package of constants for the sample sequencer
package ass_pkg;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned CHAN_W        = 4;
	localparam int unsigned DATA_W        = 16;
	localparam int unsigned FIFO_DEPTH    = 48;
	localparam int unsigned FIFO_AW       = 6;
	// intersample gap within a scan, in nanoseconds
	localparam int unsigned GAP_MIN_NS    = 5_000;
	localparam int unsigned GAP_MAX_NS    = 20_000;
	localparam int unsigned GAP_MIN_CYC   = (GAP_MIN_NS * (CLK_HZ / 1_000_000)
		+ 999) / 1000;
	localparam int unsigned GAP_MAX_CYC   = GAP_MAX_NS * (CLK_HZ / 1_000_000)
		/ 1000;
	localparam int unsigned GAP_W         = 10;

	// register offsets
	localparam logic [3:0] REG_CTRL       = 4'h0;
	localparam logic [3:0] REG_RANGE      = 4'h1;
	localparam logic [3:0] REG_THRESH     = 4'h2;
	localparam logic [3:0] REG_GAP        = 4'h3;
	localparam logic [3:0] REG_STATUS     = 4'h4;
	localparam logic [3:0] REG_DATA       = 4'h5;
	localparam logic [3:0] REG_COUNT      = 4'h6;

	// control bits
	localparam int unsigned CTRL_RUN      = 0;
	localparam int unsigned CTRL_SCAN     = 1;
	localparam int unsigned CTRL_FIFO     = 2;
	localparam int unsigned CTRL_IRQ_CLR  = 3;
	localparam int unsigned CTRL_OVF_CLR  = 4;
	// status bits
	localparam int unsigned ST_IRQ        = 0;
	localparam int unsigned ST_OVF        = 1;
	localparam int unsigned ST_BUSY       = 2;
	localparam int unsigned ST_EMPTY      = 3;
	localparam int unsigned ST_FULL       = 4;
	localparam int unsigned RANGE_HI_LSB  = 8;

	localparam logic [7:0]  RST_THRESH    = 8'h01;
	localparam logic [GAP_W-1:0] RST_GAP  = GAP_W'(GAP_MIN_CYC);

	typedef enum logic [1:0] {
		ASS_IDLE,
		ASS_CONV,
		ASS_GAP
	} ass_state_t;
endpackage

// [verilog/ass_fifo.sv]
// first-in first-out store for conversion results
`timescale 1ns/1ns
module ass_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 48,
	parameter int unsigned AW    = 6
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             clk_en,
	input  wire logic             flush,
	input  wire logic             wr_valid,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             rd_ready,
	output logic      [WIDTH-1:0] rd_data,
	output logic                  full,
	output logic                  empty,
	output logic      [AW:0]      count
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             do_wr;
	logic             do_rd;

	assign full  = (count == (AW+1)'(DEPTH));
	assign empty = (count == '0);
	assign do_wr = wr_valid && !full;
	assign do_rd = rd_ready && !empty;
	assign rd_data = mem[rd_ptr];

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge ref_clk) begin
		if (clk_en && do_wr) begin
			mem[wr_ptr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || (clk_en && flush)) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clk_en) begin
			if (do_wr) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (do_rd) begin
				rd_ptr <= bump(rd_ptr);
			end
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule // ass_fifo

// [verilog/ass_sequencer.sv]
// conversion sequencer: channel rotation, scans, fifo and interrupt request
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module ass_sequencer
	import ass_pkg::*;
#(
	parameter int unsigned CW    = ass_pkg::CHAN_W,
	parameter int unsigned DW    = ass_pkg::DATA_W,
	parameter int unsigned DEPTH = ass_pkg::FIFO_DEPTH,
	parameter int unsigned AW    = ass_pkg::FIFO_AW
) (
	input  wire logic          ref_clk,
	input  wire logic          srst,
	input  wire logic          clk_en,
	// register port
	input  wire logic [3:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [31:0]   reg_rdata,
	// conversion clock and converter
	input  wire logic          conv_tick,
	output logic               conv_start,
	output logic      [CW-1:0] conv_chan,
	input  wire logic          conv_done,
	input  wire logic [DW-1:0] conv_data,
	// interrupt request level
	output logic               irq
);
	logic             run;
	logic             scan_mode;
	logic             fifo_en;
	logic [CW-1:0]    low_chan;
	logic [CW-1:0]    high_chan;
	logic [7:0]       thresh;
	logic [GAP_W-1:0] gap_cyc;
	logic [CW-1:0]    cur_chan;
	logic [GAP_W-1:0] gap_cnt;
	logic             irq_flag;
	logic             ovf_flag;
	logic [DW-1:0]    last_data;
	logic [15:0]      sample_cnt;
	ass_state_t       state;
	ass_state_t       next_state;

	logic             ctrl_wr;
	logic             scan_last;
	logic             result_in;
	logic             fifo_full;
	logic             fifo_empty;
	logic [AW:0]      fifo_count;
	logic [DW-1:0]    fifo_rdata;
	logic             fifo_pop;
	logic             irq_set;
	logic             thresh_hit;

	function automatic logic [CW-1:0] next_chan(input logic [CW-1:0] c,
		input logic [CW-1:0] lo, input logic [CW-1:0] hi);
		next_chan = (c >= hi || c < lo) ? lo : c + 1'b1;
	endfunction

	function automatic logic reg_hit(input logic [3:0] a,
		input logic [3:0] off);
		reg_hit = (a == off);
	endfunction

	assign ctrl_wr    = clk_en && reg_wr && reg_hit(reg_addr, REG_CTRL);
	assign scan_last  = (cur_chan >= high_chan);
	assign result_in  = (state == ASS_CONV) && conv_done;
	assign fifo_pop   = clk_en && reg_rd && reg_hit(reg_addr, REG_DATA)
		&& fifo_en;
	assign conv_chan  = cur_chan;
	assign irq        = irq_flag;

	// control and configuration registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			run       <= 1'b0;
			scan_mode <= 1'b0;
			fifo_en   <= 1'b0;
			low_chan  <= '0;
			high_chan <= '0;
			thresh    <= RST_THRESH;
			gap_cyc   <= RST_GAP;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
			REG_CTRL: begin
				run       <= reg_wdata[CTRL_RUN];
				scan_mode <= reg_wdata[CTRL_SCAN];
				fifo_en   <= reg_wdata[CTRL_FIFO];
			end
			REG_RANGE: begin
				low_chan  <= reg_wdata[CW-1:0];
				high_chan <= reg_wdata[RANGE_HI_LSB +: CW];
			end
			REG_THRESH: begin
				// zero would be met by every result, so it is held at one
				thresh <= (reg_wdata[7:0] == '0) ? RST_THRESH
					: reg_wdata[7:0];
			end
			REG_GAP: begin
				// clamp to the supported intersample window
				if (reg_wdata[GAP_W-1:0] < GAP_W'(GAP_MIN_CYC)) begin
					gap_cyc <= GAP_W'(GAP_MIN_CYC);
				end else if (reg_wdata[GAP_W-1:0] > GAP_W'(GAP_MAX_CYC)) begin
					gap_cyc <= GAP_W'(GAP_MAX_CYC);
				end else begin
					gap_cyc <= reg_wdata[GAP_W-1:0];
				end
			end
			default: begin
			end
			endcase
		end
	end

	// sequencing: ticks arriving while busy are dropped
	always_comb begin
		next_state = state;
		case (state)
		ASS_IDLE: begin
			if (run && conv_tick) begin
				next_state = ASS_CONV;
			end
		end
		ASS_CONV: begin
			if (conv_done) begin
				if (scan_mode && !scan_last) begin
					next_state = ASS_GAP;
				end else begin
					next_state = ASS_IDLE;
				end
			end
		end
		ASS_GAP: begin
			if (gap_cnt == '0) begin
				next_state = ASS_CONV;
			end
		end
		default: next_state = ASS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= ASS_IDLE;
		end else if (clk_en) begin
			state <= run ? next_state : ASS_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			conv_start <= 1'b0;
		end else if (clk_en) begin
			conv_start <= run && (next_state == ASS_CONV)
				&& (state != ASS_CONV);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			gap_cnt <= '0;
		end else if (clk_en) begin
			if (result_in) begin
				gap_cnt <= gap_cyc - 1'b1;
			end else if (state == ASS_GAP && gap_cnt != '0) begin
				gap_cnt <= gap_cnt - 1'b1;
			end
		end
	end

	// channel pointer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cur_chan <= '0;
		end else if (clk_en) begin
			if (!run || (reg_wr && reg_hit(reg_addr, REG_RANGE))) begin
				cur_chan <= reg_wr && reg_hit(reg_addr, REG_RANGE)
					? reg_wdata[CW-1:0] : low_chan;
			end else if (state == ASS_IDLE && scan_mode && conv_tick) begin
				cur_chan <= low_chan;
			end else if (result_in) begin
				// scan ends back at low, single rotates
				cur_chan <= next_chan(cur_chan, low_chan,
					high_chan);
			end
		end
	end

	ass_fifo #(
		.WIDTH (DW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.clk_en   (clk_en),
		.flush    (!fifo_en),
		.wr_valid (result_in && fifo_en),
		.wr_data  (conv_data),
		.rd_ready (fifo_pop),
		.rd_data  (fifo_rdata),
		.full     (fifo_full),
		.empty    (fifo_empty),
		.count    (fifo_count)
	);

	// latest result for the fifo-less path
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			last_data <= '0;
		end else if (clk_en && result_in && !fifo_en) begin
			last_data <= conv_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sample_cnt <= '0;
		end else if (clk_en && result_in) begin
			sample_cnt <= sample_cnt + 1'b1;
		end
	end

	// widened so a large threshold is never cut down to a small one
	assign thresh_hit = (9'(fifo_count) >= 9'(thresh))
		|| (result_in && 9'(fifo_count) + 9'h001 >= 9'(thresh));

	// interrupt request sources
	always_comb begin
		irq_set = 1'b0;
		if (result_in) begin
			if (!fifo_en) begin
				irq_set = !scan_mode || scan_last;
			end else begin
				// a scan completes before the threshold may fire
				irq_set = thresh_hit && (!scan_mode || scan_last);
			end
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_flag <= 1'b0;
		end else if (clk_en) begin
			if (irq_set) begin
				irq_flag <= 1'b1;
			end else if (ctrl_wr && reg_wdata[CTRL_IRQ_CLR]) begin
				irq_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ovf_flag <= 1'b0;
		end else if (clk_en) begin
			if (result_in && fifo_en && fifo_full) begin
				ovf_flag <= 1'b1;
			end else if (ctrl_wr && reg_wdata[CTRL_OVF_CLR]) begin
				ovf_flag <= 1'b0;
			end
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			reg_rdata <= '0;
			if (reg_rd) begin
				case (reg_addr)
				REG_CTRL: begin
					reg_rdata[CTRL_RUN]  <= run;
					reg_rdata[CTRL_SCAN] <= scan_mode;
					reg_rdata[CTRL_FIFO] <= fifo_en;
				end
				REG_RANGE: begin
					reg_rdata[CW-1:0] <= low_chan;
					reg_rdata[RANGE_HI_LSB +: CW] <= high_chan;
				end
				REG_THRESH: reg_rdata[7:0] <= thresh;
				REG_GAP: reg_rdata[GAP_W-1:0] <= gap_cyc;
				REG_STATUS: begin
					reg_rdata[ST_IRQ]   <= irq_flag;
					reg_rdata[ST_OVF]   <= ovf_flag;
					reg_rdata[ST_BUSY]  <= (state != ASS_IDLE);
					reg_rdata[ST_EMPTY] <= fifo_empty;
					reg_rdata[ST_FULL]  <= fifo_full;
				end
				REG_DATA: reg_rdata[DW-1:0] <= fifo_en ? fifo_rdata
					: last_data;
				REG_COUNT: begin
					reg_rdata[AW:0]   <= fifo_count;
					reg_rdata[31:16]  <= sample_cnt;
				end
				default: reg_rdata <= '0;
				endcase
			end
		end
	end
endmodule // ass_sequencer

// [verif/ass_checker.sv]
// port checker for the sample sequencer
`timescale 1ns/1ns
module ass_checker
	import ass_pkg::*;
#(
	parameter int unsigned CW = 4, DW = 16, DEPTH = 48, AW = 6
) (
	input wire logic          ref_clk,
	input wire logic          srst,
	input wire logic          clk_en,
	input wire logic [3:0]    reg_addr,
	input wire logic [31:0]   reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [31:0]   reg_rdata,
	input wire logic          conv_tick,
	input wire logic          conv_start,
	input wire logic [CW-1:0] conv_chan,
	input wire logic          conv_done,
	input wire logic [DW-1:0] conv_data,
	input wire logic          irq
);
	logic          pend, have, scn, wt;
	logic [CW-1:0] lo_h, hi_h;
	logic [10:0]   gap;
	wire           ctl = reg_wr && reg_addr == REG_CTRL;
	wire           clr = ctl && reg_wdata[CTRL_IRQ_CLR];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend <= 1'b0;
			have <= 1'b0;
			scn <= 1'b0;
			wt <= 1'b0;
		end else begin
			pend <= conv_start | (pend & ~conv_done);
			if (conv_start || ctl)
				wt <= 1'b0;
			else if (conv_done && scn && conv_chan != hi_h)
				wt <= 1'b1;
			if (ctl)
				scn <= reg_wdata[CTRL_SCAN];
			if (reg_wr && reg_addr == REG_RANGE) begin
				have <= 1'b1;
				lo_h <= reg_wdata[CW-1:0];
				hi_h <= reg_wdata[RANGE_HI_LSB+:CW];
			end
		end
		// held at its top so a long idle never wraps into a false gap
		gap <= conv_done ? 11'h0 : gap + {10'h0, gap != 11'h7ff};
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	chk_one_pending: assert property (conv_start |-> !pend)
		else $error("start while a conversion is pending");
	chk_chan_range: assert property (conv_start && have && lo_h <= hi_h
		|-> conv_chan >= lo_h && conv_chan <= hi_h)
		else $error("channel outside the range");
	chk_chan_hold: assert property (pend |-> $stable(conv_chan))
		else $error("channel moved during a conversion");
	chk_scan_gap: assert property (conv_start && scn && conv_chan != lo_h
		|-> gap >= 11'h0f0 && gap <= 11'h3f2)
		else $error("scan gap out of bounds");
	// the wait is counted in gap, which saturates if the scan stalls
	chk_scan_next: assert property (wt |-> gap <= 11'h3f2)
		else $error("scan did not go on");
	chk_irq_cause: assert property ($rose(irq) |-> $past(conv_done))
		else $error("irq without a result");
	chk_irq_sticky: assert property (irq && !clr |=> irq)
		else $error("irq dropped without clear");
	chk_irq_clear: assert property (clr && !conv_done |=> !irq)
		else $error("irq not cleared");
endmodule // ass_checker

bind ass_sequencer ass_checker #(.CW(CW), .DW(DW), .DEPTH(DEPTH), .AW(AW))
	u_chk (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_tick(conv_tick),
	.conv_start(conv_start), .conv_chan(conv_chan),
	.conv_done(conv_done), .conv_data(conv_data), .irq(irq));

// [verif/ass_conv_model.sv]
// converter model answering each start after a short or long wait
`timescale 1ns/1ns
module ass_conv_model
	import ass_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic              slow,
	input  wire logic              conv_start,
	input  wire logic [CHAN_W-1:0] conv_chan,
	output logic                   conv_done,
	output logic      [DATA_W-1:0] conv_data
);
	logic              busy;
	logic [4:0]        wait_cnt;
	logic [CHAN_W-1:0] ch;
	logic [11:0]       k;

	initial begin
		conv_done = 1'b0;
		conv_data = '0;
	end
	always @(posedge ref_clk) begin
		conv_done <= 1'b0;
		// the word is only meaningful with the strobe, so never hold it
		conv_data <= ~conv_data;
		if (srst) begin
			busy <= 1'b0;
			k <= 12'h0;
		end else if (conv_start) begin
			busy <= 1'b1;
			ch <= conv_chan;
			wait_cnt <= slow ? 5'h14 : 5'h1;
		end else if (busy && wait_cnt == 5'h0) begin
			busy <= 1'b0;
			conv_done <= 1'b1;
			conv_data <= {ch, k};
			k <= k + 12'h1;
		end else if (busy) begin
			wait_cnt <= wait_cnt - 5'h1;
		end
	end
endmodule // ass_conv_model

// [verif/adc_sample_sequencer_fifo_irq_test.sv]
// self-checking bench for the sample sequencer
`timescale 1ns/1ns
module adc_sample_sequencer_fifo_irq_test;
	import ass_pkg::*;
	logic              ref_clk, srst, clk_en, reg_wr, reg_rd, conv_tick;
	logic              conv_start, conv_done, irq, slow;
	logic [3:0]        reg_addr;
	logic [31:0]       reg_wdata, reg_rdata, ctrl, d;
	logic [CHAN_W-1:0] conv_chan, lo, hi, exp_ch;
	logic [DATA_W-1:0] conv_data;
	logic [DATA_W-1:0] q[$];
	logic [11:0]       k;
	int                n_errors, check_count, t, xfer, total;
	localparam int     HBUF = 8;
	logic [DATA_W-1:0] hbuf[HBUF];
	localparam logic [31:0] RUN = 32'h1 << CTRL_RUN;
	localparam logic [31:0] SCN = 32'h1 << CTRL_SCAN;
	localparam logic [31:0] FIF = 32'h1 << CTRL_FIFO;

	ass_sequencer uut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_tick(conv_tick),
		.conv_start(conv_start), .conv_chan(conv_chan),
		.conv_done(conv_done), .conv_data(conv_data), .irq(irq));
	ass_conv_model conv (.ref_clk(ref_clk), .srst(srst), .slow(slow),
		.conv_start(conv_start), .conv_chan(conv_chan),
		.conv_done(conv_done), .conv_data(conv_data));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic setup(input logic [31:0] c, input int th, input int span);
		wr(REG_CTRL, 32'h18);
		lo = CHAN_W'($urandom % 8);
		hi = lo + CHAN_W'(span);
		exp_ch = lo;
		ctrl = c;
		q.delete();
		wr(REG_RANGE, (32'(hi) << RANGE_HI_LSB) | 32'(lo));
		wr(REG_THRESH, th);
		wr(REG_CTRL, c);
	endtask
	// one tick, sometimes two cycles long so the second is refused as busy
	task automatic one(input int n, input logic last_irq);
		int i;
		slow <= 1'($urandom % 2);
		conv_tick <= 1'b1;
		repeat ($urandom % 2 + 1) @(posedge ref_clk);
		conv_tick <= 1'b0;
		for (int j = 0; j < n; j++) begin
			for (i = 0; i < 1100 && conv_start !== 1'b1; i++) @(posedge ref_clk);
			cmp(conv_chan, exp_ch);
			q.push_back({exp_ch, k});
			k++;
			exp_ch = (exp_ch == hi) ? lo : exp_ch + 1'b1;
			for (i = 0; i < 40 && conv_done !== 1'b1; i++) @(posedge ref_clk);
			@(posedge ref_clk);
			cmp(irq, (j == n - 1) ? last_irq : 1'b0);
		end
	endtask
	task automatic drain(input int n);
		repeat (n) begin
			rd(REG_DATA);
			cmp(d, q.pop_front());
			// host side ring buffer with its two transfer counters
			hbuf[xfer] = d[DATA_W-1:0];
			total++;
			xfer = (xfer == HBUF - 1) ? 0 : xfer + 1;
		end
	endtask

	initial begin
		{srst, clk_en} = 2'b11;
		{reg_wr, reg_rd, conv_tick, slow} = 4'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		{n_errors, check_count, k, xfer, total} = '0;
		void'($urandom(86350));
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd(REG_THRESH);
		cmp(d, 32'(RST_THRESH));
		// a write while the clock enable is low must be lost
		clk_en <= 1'b0;
		wr(REG_THRESH, 32'h5);
		clk_en <= 1'b1;
		rd(REG_THRESH);
		cmp(d, 32'(RST_THRESH));
		rd(4'h7);
		cmp(d, 32'h0);
		wr(REG_GAP, 32'h3);
		rd(REG_GAP);
		cmp(d, GAP_MIN_CYC);
		t = GAP_MIN_CYC + $urandom % 100;
		wr(REG_GAP, t);
		rd(REG_GAP);
		cmp(d, t);
		setup(RUN, 1, $urandom % 8);
		repeat (int'(hi - lo) + 2) begin
			one(1, 1'b1);
			rd(REG_DATA);
			cmp(d, q[$]);
			wr(REG_CTRL, ctrl | 32'h8);
		end
		setup(RUN | SCN, 1, $urandom % 4 + 1);
		repeat (2) begin
			one(int'(hi - lo) + 1, 1'b1);
			rd(REG_DATA);
			cmp(d, q[$]);
			wr(REG_CTRL, ctrl | 32'h8);
		end
		t = 2 + $urandom % 4;
		setup(RUN | FIF, t, $urandom % 8);
		for (int i = 0; i < t; i++)
			one(1, i == t - 1);
		drain(t);
		setup(RUN | FIF, 255, $urandom % 8);
		repeat (FIFO_DEPTH + 1)
			one(1, 1'b0);
		rd(REG_STATUS);
		cmp({d[ST_OVF], d[ST_FULL]}, 2'b11);
		void'(q.pop_back());
		drain(FIFO_DEPTH);
		wr(REG_CTRL, ctrl | 32'h10);
		rd(REG_STATUS);
		cmp({d[ST_OVF], d[ST_EMPTY]}, 2'b01);
		setup(RUN | SCN | FIF, 1, 2);
		one(3, 1'b1);
		drain(3);
		cmp(total, t + FIFO_DEPTH + 3);
		cmp(xfer, (t + FIFO_DEPTH + 3) % HBUF);
		// one-shot host: the requested count is in, so it stops the run
		wr(REG_CTRL, 32'h0);
		conv_tick <= 1'b1;
		@(posedge ref_clk);
		conv_tick <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(REG_STATUS);
		cmp(d[ST_BUSY], 1'b0);
		rd(REG_COUNT);
		cmp(d, {16'(k), 16'h0});
		close_out();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_errors++;
		close_out();
	end
endmodule // adc_sample_sequencer_fifo_irq_test
